// ---- rtl/dbc_pkg.sv ----
// Shared constants and carrier types for the debug communications channel
package dbc_pkg;

   localparam int          DATA_W         = 32;
   localparam int          RSP_FIFO_DEPTH = 8;

   // Core-side coprocessor register numbers
   localparam logic [3:0]  CP_REG_STATUS  = 4'h1;
   localparam logic [3:0]  CP_REG_DATA    = 4'h5;

   // Debugger-side register indices; byte address is index times four
   localparam logic [7:0]  DBG_REG_RX     = 8'h20;
   localparam logic [7:0]  DBG_REG_STATUS = 8'h22;
   localparam logic [7:0]  DBG_REG_TX     = 8'h23;

   // Flag positions inside the status word
   localparam int          RX_FULL_BIT    = 30;
   localparam int          TX_FULL_BIT    = 29;

   localparam logic        FLAG_RESET     = 1'h0;
   localparam logic [31:0] WORD_RESET     = 32'h0000_0000;

   typedef struct packed {
      logic        write;
      logic [3:0]  regnum;
      logic [31:0] wdata;
   } dbc_cp_req_t;

   typedef struct packed {
      logic        write;
      logic [7:0]  index;
      logic [31:0] wdata;
   } dbc_dbg_req_t;

endpackage

// ---- rtl/dbc_fifo.sv ----
// Parameterised synchronous FIFO with valid/ready on both sides
`timescale 1ns/10ps
`default_nettype none
module dbc_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 8
) (
   input  wire logic             clk_in,
   input  wire logic             reset_n_in,
   input  wire logic             in_valid_in,
   output var  logic             in_ready_out,
   input  wire logic [WIDTH-1:0] in_data_in,
   output var  logic             out_valid_out,
   input  wire logic             out_ready_in,
   output var  logic [WIDTH-1:0] out_data_out
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   typedef struct packed {
      logic [AW-1:0] wr_ptr;
      logic [AW-1:0] rd_ptr;
      logic [AW:0]   count;
      logic          in_ready;
      logic          out_valid;
   } dbc_fifo_state_t;

   dbc_fifo_state_t  st;
   dbc_fifo_state_t  next_st;
   logic [WIDTH-1:0] mem [DEPTH];
   logic             push;
   logic             pop;

   assign push          = in_valid_in & st.in_ready;
   assign pop           = out_ready_in & st.out_valid;
   assign in_ready_out  = st.in_ready;
   assign out_valid_out = st.out_valid;
   assign out_data_out  = mem[st.rd_ptr];

   always_comb
   begin
      next_st = st;
      if (push)
      begin
         next_st.wr_ptr = (st.wr_ptr == AW'(DEPTH - 1)) ? '0 : st.wr_ptr + 1'b1;
      end
      if (pop)
      begin
         next_st.rd_ptr = (st.rd_ptr == AW'(DEPTH - 1)) ? '0 : st.rd_ptr + 1'b1;
      end
      next_st.count     = st.count + (AW+1)'(push) - (AW+1)'(pop);
      // Flags kept as flops so the ports see no decode glitches
      next_st.in_ready  = (next_st.count != (AW+1)'(DEPTH));
      next_st.out_valid = (next_st.count != '0);
   end

   always_ff @(posedge clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         st <= '{wr_ptr: '0, rd_ptr: '0, count: '0, in_ready: 1'b1, out_valid: 1'b0};
      end
      else
      begin
         st <= next_st;
      end
   end

   // Storage has no reset; only the pointers define what is valid
   always_ff @(posedge clk_in)
   begin
      if (push)
      begin
         mem[st.wr_ptr] <= in_data_in;
      end
   end
endmodule
`default_nettype wire

// ---- rtl/dbc_channel.sv ----
// Debug communications channel: two one-word mailboxes between core and debugger
// What this block does and what core software and the debugger must do
// [R1] After the core saw the receive flag set, its next data read returns the debugger's word and clears the flag.
// [R2] A core data read with the receive flag clear returns whatever the word register holds.
// [R3] A core data write stores all 32 bits and sets the transmit flag, with no gap needed.
// [R4] Core software does not write the data register while the transmit flag is set.
// [R5] A debugger write to the receive register with the flag clear hands the word to the core and sets the flag.
// [R6] A debugger write to the receive register with the flag set is dropped, word and flag unchanged.
// [R7] A debugger read of the transmit register with the flag set returns the core's word and clears the flag.
// [R8] A debugger read of the transmit register with the flag clear leaves the flag alone.
// [R9] Each party polls only its own status view before using its own data path.
// [R10] The core reaches the channel only through coprocessor register 1 (status) and 5 (data).
// [R11] Core sender loops on status until the transmit flag clears, then writes register 5.
// [R12] Core receiver loops on status until the receive flag sets, then reads register 5.
// [R13] The debugger reads status index 34 and, with bit 29 set, takes the word from index 35.
// [R14] The debugger writes index 32 only while status bit 30 reads clear.
// [R15] The debugger polls the status regularly while the core runs.
// [R16] The channel works whether or not the core is halted.
// [R17] Both flags reset to zero and both status views show the same two flags.
`timescale 1ns/10ps
`default_nettype none
module dbc_channel (
   input  wire logic                 clk_in,
   input  wire logic                 reset_n_in,
   input  wire logic                 cp_valid_in,
   input  wire dbc_pkg::dbc_cp_req_t cp_req_in,
   output var  logic                 cp_rvalid_out,
   output var  logic [31:0]          cp_rdata_out,
   input  wire logic                 dbg_req_valid_in,
   output var  logic                 dbg_req_ready_out,
   input  wire dbc_pkg::dbc_dbg_req_t dbg_req_in,
   output var  logic                 dbg_rsp_valid_out,
   input  wire logic                 dbg_rsp_ready_in,
   output var  logic [31:0]          dbg_rsp_data_out,
   output var  logic                 rx_channel_full_out,
   output var  logic                 tx_channel_full_out
);
   typedef struct packed {
      logic        rx_channel_full;
      logic        tx_channel_full;
      logic [31:0] host_to_core_word;
      logic [31:0] core_to_host_word;
      logic        cp_rvalid;
      logic [31:0] cp_rdata;
      logic        rsp_valid;
      logic [31:0] rsp_data;
   } dbc_state_t;

   // Decoded strobes, shared by the flag update and its collision guard
   typedef struct packed {
      logic cp_read;
      logic cp_wr_data;
      logic dbg_wr_rx;
      logic dbg_rd_tx;
   } dbc_hit_t;

   dbc_state_t  st;
   dbc_state_t  next_st;
   logic        fifo_in_ready;
   logic        fifo_out_valid;
   logic        fifo_out_ready;
   logic [31:0] fifo_out_data;
   logic        dbg_take;
   logic [31:0] dbg_read_word;
   dbc_hit_t    hit;

   // One status layout serves both views so they can never disagree
   function automatic logic [31:0] status_word(input logic rx_full, input logic tx_full);
      logic [31:0] w;
      w = 32'h0000_0000;
      w[dbc_pkg::RX_FULL_BIT] = rx_full;
      w[dbc_pkg::TX_FULL_BIT] = tx_full;
      return w;
   endfunction

   function automatic logic cp_hit(input dbc_pkg::dbc_cp_req_t req, input logic wr, input logic [3:0] regnum);
      return req.write == wr && req.regnum == regnum;
   endfunction

   function automatic logic dbg_hit(input dbc_pkg::dbc_dbg_req_t req, input logic wr, input logic [7:0] index);
      return req.write == wr && req.index == index;
   endfunction

   assign dbg_take       = dbg_req_valid_in & fifo_in_ready;
   assign fifo_out_ready = !st.rsp_valid | dbg_rsp_ready_in;

   always_comb
   begin
      hit.cp_read    = cp_valid_in && !cp_req_in.write;
      hit.cp_wr_data = cp_valid_in && cp_hit(cp_req_in, 1'b1, dbc_pkg::CP_REG_DATA);
      hit.dbg_wr_rx  = dbg_take && dbg_hit(dbg_req_in, 1'b1, dbc_pkg::DBG_REG_RX);
      hit.dbg_rd_tx  = dbg_take && dbg_hit(dbg_req_in, 1'b0, dbc_pkg::DBG_REG_TX);
   end

   // Read answer captured at acceptance, so later flag changes cannot alter it
   always_comb
   begin
      unique case (dbg_req_in.index)
         dbc_pkg::DBG_REG_STATUS : dbg_read_word = status_word(st.rx_channel_full, st.tx_channel_full); // R17
         dbc_pkg::DBG_REG_TX     : dbg_read_word = st.core_to_host_word; // R8
         default                 : dbg_read_word = 32'h0000_0000;
      endcase
   end

   always_comb
   begin
      next_st           = st;
      next_st.cp_rvalid = 1'b0;

      // Core side
      if (hit.cp_read)
      begin
         next_st.cp_rvalid = 1'b1;
         unique case (cp_req_in.regnum)
            dbc_pkg::CP_REG_STATUS : next_st.cp_rdata = status_word(st.rx_channel_full, st.tx_channel_full); // R10
            dbc_pkg::CP_REG_DATA   :
            begin
               // Word returned even when empty; its value then means nothing
               next_st.cp_rdata        = st.host_to_core_word; // R1 R2
               next_st.rx_channel_full = 1'b0; // R1
            end
            default                : next_st.cp_rdata = 32'h0000_0000;
         endcase
      end
      if (hit.cp_wr_data)
      begin
         // Overwrite while full is left to software to avoid
         next_st.core_to_host_word = cp_req_in.wdata; // R3 R4
         next_st.tx_channel_full   = 1'b1; // R3
      end

      // Debugger side; a set in the same cycle as a clear wins
      if (hit.dbg_wr_rx && !st.rx_channel_full) // R6
      begin
         next_st.host_to_core_word = dbg_req_in.wdata; // R5
         next_st.rx_channel_full   = 1'b1; // R5
      end
      if (hit.dbg_rd_tx && st.tx_channel_full)
      begin
         if (!hit.cp_wr_data)
         begin
            next_st.tx_channel_full = 1'b0; // R7
         end
      end

      // Answer stage fed from the FIFO, stalls with the debugger
      if (fifo_out_ready)
      begin
         next_st.rsp_valid = fifo_out_valid;
         next_st.rsp_data  = fifo_out_data;
      end
   end

   always_ff @(posedge clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         st <= '{rx_channel_full: dbc_pkg::FLAG_RESET,
                 tx_channel_full: dbc_pkg::FLAG_RESET,
                 host_to_core_word: dbc_pkg::WORD_RESET,
                 core_to_host_word: dbc_pkg::WORD_RESET,
                 cp_rvalid: 1'b0,
                 cp_rdata: dbc_pkg::WORD_RESET,
                 rsp_valid: 1'b0,
                 rsp_data: dbc_pkg::WORD_RESET}; // R17
      end
      else
      begin
         st <= next_st;
      end
   end

   // Debugger read answers queue here so a slow debugger back-pressures its requests
   dbc_fifo #(
      .WIDTH (dbc_pkg::DATA_W),
      .DEPTH (dbc_pkg::RSP_FIFO_DEPTH)
   ) u_rsp_fifo (
      .clk_in        (clk_in),
      .reset_n_in    (reset_n_in),
      .in_valid_in   (dbg_req_valid_in & !dbg_req_in.write),
      .in_ready_out  (fifo_in_ready),
      .in_data_in    (dbg_read_word),
      .out_valid_out (fifo_out_valid),
      .out_ready_in  (fifo_out_ready),
      .out_data_out  (fifo_out_data)
   );

   assign dbg_req_ready_out   = fifo_in_ready;
   assign cp_rvalid_out       = st.cp_rvalid;
   assign cp_rdata_out        = st.cp_rdata;
   assign dbg_rsp_valid_out   = st.rsp_valid;
   assign dbg_rsp_data_out    = st.rsp_data;
   assign rx_channel_full_out = st.rx_channel_full; // R16
   assign tx_channel_full_out = st.tx_channel_full;
endmodule
`default_nettype wire

// ---- bench/dbc_channel_props.sv ----
// Port assertions for the debug channel
`timescale 1ns/10ps
`default_nettype none
module dbc_channel_props (
   input wire logic                  clk_in,
   input wire logic                  reset_n_in,
   input wire logic                  cp_valid_in,
   input wire dbc_pkg::dbc_cp_req_t  cp_req_in,
   input wire logic                  cp_rvalid_out,
   input wire logic [31:0]           cp_rdata_out,
   input wire logic                  dbg_req_valid_in,
   input wire logic                  dbg_req_ready_out,
   input wire dbc_pkg::dbc_dbg_req_t dbg_req_in,
   input wire logic                  dbg_rsp_valid_out,
   input wire logic                  dbg_rsp_ready_in,
   input wire logic [31:0]           dbg_rsp_data_out,
   input wire logic                  rx_channel_full_out,
   input wire logic                  tx_channel_full_out
);
   wire         rx = rx_channel_full_out;
   wire         tx = tx_channel_full_out;
   wire         c5 = cp_valid_in && cp_req_in.regnum == 4'h5;
   wire         dt = dbg_req_valid_in && dbg_req_ready_out;
   wire         crd = c5 && !cp_req_in.write;
   wire         cwr = c5 && cp_req_in.write;
   wire         dwr = dt && dbg_req_in.write && dbg_req_in.index == 8'h20;
   wire         drd = dt && !dbg_req_in.write && dbg_req_in.index == 8'h23;
   logic [31:0] rxw;
   // Last word the core may accept; refused writes leave it alone
   always_ff @(posedge clk_in or negedge reset_n_in)
      if (!reset_n_in)
         rxw <= 32'h0;
      else if (dwr && !rx)
         rxw <= dbg_req_in.wdata;
   default clocking @(posedge clk_in); endclocking
   default disable iff (!reset_n_in);
   property p_rxclr; crd && rx && !dwr |=> !rx; endproperty
   property p_rxdat; crd && rx |=> cp_rvalid_out && cp_rdata_out == rxw; endproperty
   property p_txset; cwr |=> tx; endproperty
   property p_rxset; dwr && !rx |=> rx; endproperty
   property p_rxign; dwr && rx && !crd |=> rx; endproperty
   property p_txclr; drd && tx && !cwr |=> !tx; endproperty
   property p_txkeep; drd && !tx && !cwr |=> !tx; endproperty
   property p_rvld; cp_rvalid_out == $past(cp_valid_in && !cp_req_in.write); endproperty
   property p_stat; cp_valid_in && !cp_req_in.write && cp_req_in.regnum == 4'h1
      |=> cp_rdata_out == {1'b0, $past(rx), $past(tx), 29'h0}; endproperty
   property p_hold; dbg_rsp_valid_out && !dbg_rsp_ready_in |=> dbg_rsp_valid_out && $stable(dbg_rsp_data_out);
   endproperty
   a_rxclr: assert property (p_rxclr) else $error("rx flag kept");
   a_rxdat: assert property (p_rxdat) else $error("core read word");
   a_txset: assert property (p_txset) else $error("tx flag not set");
   a_rxset: assert property (p_rxset) else $error("rx flag not set");
   a_rxign: assert property (p_rxign) else $error("rx flag lost");
   a_txclr: assert property (p_txclr) else $error("tx flag kept");
   a_txkeep: assert property (p_txkeep) else $error("tx flag moved");
   a_rvld: assert property (p_rvld) else $error("core answer");
   a_stat: assert property (p_stat) else $error("core status");
   a_hold: assert property (p_hold) else $error("answer dropped");
   c_drd: cover property (drd && tx);
   c_dwr: cover property (dwr && rx);
   c_stall: cover property (dbg_rsp_valid_out && !dbg_req_ready_out);
   c_col: cover property (cwr && drd);
endmodule
bind dbc_channel dbc_channel_props dbc_channel_props_i (.*);
`default_nettype wire

// ---- bench/dbc_dbg_model.sv ----
// Debugger-side model: posts requests, collects answers
`timescale 1ns/10ps
`default_nettype none
module dbc_dbg_model (
   input  wire logic                  clk_in,
   input  wire logic                  stall_in,
   input  wire logic                  req_ready_in,
   output var  dbc_pkg::dbc_dbg_req_t req_out,
   output var  logic                  req_valid_out,
   input  wire logic                  rsp_valid_in,
   input  wire logic [31:0]           rsp_data_in,
   output var  logic                  rsp_ready_out
);
   logic [31:0] rq[$];
   initial
   begin
      req_valid_out = 1'b0;
      req_out = '0;
      rsp_ready_out = 1'b0;
   end
   // Random stalls so answers pile up
   always @(posedge clk_in)
   begin
      if (rsp_valid_in && rsp_ready_out)
         rq.push_back(rsp_data_in);
      #1 rsp_ready_out = !stall_in && ($urandom % 3 != 0);
   end
   task automatic post(input logic w, input logic [7:0] ix, input logic [31:0] d);
      @(posedge clk_in);
      #1 req_valid_out = 1'b1;
      req_out = '{w, ix, d};
      while (!req_ready_in)
         @(posedge clk_in) #1;
      @(posedge clk_in) #1;
      req_valid_out = 1'b0;
      // Released data is flipped, never left looking valid
      req_out.wdata = ~d;
   endtask
endmodule
`default_nettype wire

// ---- bench/dbc_channel_tb_top.sv ----
// Self-checking bench for the debug channel
`timescale 1ns/10ps
`default_nettype none
module dbc_channel_tb_top;
   logic                  clk_in = 1'b0;
   logic                  reset_n_in = 1'b0;
   logic                  cp_valid_in = 1'b0;
   dbc_pkg::dbc_cp_req_t  cp_req_in = '0;
   dbc_pkg::dbc_dbg_req_t dbg_req_in;
   logic                  cp_rvalid_out, dbg_req_valid_in, dbg_req_ready_out;
   logic                  dbg_rsp_valid_out, dbg_rsp_ready_in, rx_channel_full_out, tx_channel_full_out;
   logic [31:0]           cp_rdata_out, dbg_rsp_data_out, q, w, rxw = '0, txw = '0;
   logic                  stall = 1'b0, rx = 1'b0, tx = 1'b0;
   int                    failures = 0, comparisons = 0, n;
   always #50 clk_in = ~clk_in;
   dbc_channel dbc_channel_i (.*);
   dbc_dbg_model dbc_dbg_model_i (.clk_in(clk_in), .stall_in(stall), .req_ready_in(dbg_req_ready_out),
      .req_out(dbg_req_in), .req_valid_out(dbg_req_valid_in), .rsp_valid_in(dbg_rsp_valid_out),
      .rsp_data_in(dbg_rsp_data_out), .rsp_ready_out(dbg_rsp_ready_in));
   function automatic logic [31:0] stw(input logic r, t);
      return {1'b0, r, t, 29'h0};
   endfunction
   task automatic chk(input string nm, input logic [31:0] s, e);
      comparisons++;
      if (s !== e)
      begin
         failures++;
         $display("[ERR] %s exp %h got %h", nm, e, s);
      end
   endtask
   task automatic fl;
      chk("rxf", {31'h0, rx_channel_full_out}, {31'h0, rx});
      chk("txf", {31'h0, tx_channel_full_out}, {31'h0, tx});
   endtask
   task automatic cp(input logic wr, input logic [3:0] r, input logic [31:0] d, output logic [31:0] o);
      @(posedge clk_in) #1;
      cp_valid_in = 1'b1;
      cp_req_in = '{wr, r, d};
      @(posedge clk_in) #1;
      cp_valid_in = 1'b0;
      o = cp_rdata_out;
      chk("crv", {31'h0, cp_rvalid_out}, {31'h0, !wr});
   endtask
   task automatic dr(input logic [7:0] ix, output logic [31:0] o);
      dbc_dbg_model_i.post(1'b0, ix, 32'h0);
      while (dbc_dbg_model_i.rq.size() == 0)
         #100;
      o = dbc_dbg_model_i.rq.pop_front();
   endtask
   task automatic close_out;
      $display("comparisons %0d mismatches %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   initial
   begin
      #3_000_000 failures++;
      close_out();
   end
   initial
   begin
      void'($urandom(32'hEF10147E));
      repeat (4) @(posedge clk_in);
      #1 reset_n_in = 1'b1;
      fl();
      for (int i = 0; i < 60; i++)
      begin
         w = $urandom;
         case ($urandom % 4)
            0, 1:
            begin
               cp(1'b0, 4'h1, 32'h0, q);
               chk("cst", q, stw(rx, tx));
               if (!q[29] && !q[30])
               begin
                  cp(1'b1, 4'h5, w, q);
                  {tx, txw} = {1'b1, w};
               end
               else if (q[30])
               begin
                  cp(1'b0, 4'h5, 32'h0, q);
                  chk("c5", q, rxw);
                  rx = 1'b0;
               end
            end
            default:
            begin
               dr(8'h22, q);
               chk("dst", q, stw(rx, tx));
               if (q[29])
               begin
                  dr(8'h23, q);
                  chk("d35", q, txw);
                  tx = 1'b0;
               end
               else if (!q[30])
               begin
                  dbc_dbg_model_i.post(1'b1, 8'h20, w);
                  {rx, rxw} = {1'b1, w};
               end
            end
         endcase
         fl();
      end
      $display("test random done");
      if (!rx)
         dbc_dbg_model_i.post(1'b1, 8'h20, rxw);
      rx = 1'b1;
      dbc_dbg_model_i.post(1'b1, 8'h20, ~rxw);
      fl();
      cp(1'b0, 4'h5, 32'h0, q);
      chk("ign", q, rxw);
      rx = 1'b0;
      cp(1'b0, 4'h5, 32'h0, q);
      fl();
      if (tx)
         dr(8'h23, q);
      tx = 1'b0;
      dr(8'h23, q);
      fl();
      cp(1'b0, 4'h3, 32'h0, q);
      chk("cun", q, 32'h0);
      dr(8'h21, q);
      chk("dun", q, 32'h0);
      // Same-edge collisions: the set must win over the refused clear
      fork
         cp(1'b1, 4'h5, w, q);
         dr(8'h23, q);
      join
      {tx, txw} = {1'b1, w};
      fl();
      dr(8'h23, q);
      chk("txc", q, txw);
      tx = 1'b0;
      fork
         cp(1'b0, 4'h5, 32'h0, q);
         dbc_dbg_model_i.post(1'b1, 8'h20, ~w);
      join
      {rx, rxw} = {1'b1, ~w};
      fl();
      cp(1'b0, 4'h5, 32'h0, q);
      chk("rxc", q, rxw);
      rx = 1'b0;
      fl();
      $display("test corner done");
      stall = 1'b1;
      n = 0;
      while (n < 12 && dbg_req_ready_out)
      begin
         dbc_dbg_model_i.post(1'b0, 8'h22, 32'h0);
         n++;
      end
      chk("rdy", {31'h0, dbg_req_ready_out}, 32'h0);
      chk("cap", n, dbc_pkg::RSP_FIFO_DEPTH + 1);
      stall = 1'b0;
      while (dbc_dbg_model_i.rq.size() < n)
         #100;
      repeat (n) chk("fifo", dbc_dbg_model_i.rq.pop_front(), stw(rx, tx));
      $display("test buffer done");
      cp(1'b1, 4'h5, w, q);
      reset_n_in = 1'b0;
      repeat (2) @(posedge clk_in);
      #1 reset_n_in = 1'b1;
      {rx, tx} = 2'h0;
      fl();
      $display("test reset done");
      close_out();
   end
endmodule
`default_nettype wire
